// File: verilog/bus_hold_arbiter.sv
// external bus hold arbitration with shared extension memory access
// What this block does
// - finish running bus cycle before acknowledging yield
// - select strobes undriven after bus release
// - latched strobes driven high one half period
// - regain starts once yield request is high (level) while held
// - master may drop request unasked; regain normally
// - held plus sharing mode: memory as sram
module bus_hold_arbiter
	import bus_hold_pkg::*;
#(
	parameter int NSEL = NUM_SEL,
	parameter int AW   = MEM_ADDR_W,
	parameter int DW   = MEM_DATA_W
) (
	// clock and reset
	input  wire logic            sys_clk,
	input  wire logic            reset_n,
	// hold handshake, yield request active low
	input  wire logic            hold_req_n,
	output logic                 yield_acknowledge_n,
	output logic                 bus_reclaim_request_n,
	// internal bus controller
	input  wire logic            cycle_busy,
	input  wire logic            access_pending,
	input  wire logic [NSEL-1:0] sel_latched,
	input  wire logic [NSEL-1:0] sel_value_n,
	output logic                 bus_owned,
	// select strobe pins
	output logic      [NSEL-1:0] select_strobes_o,
	output logic      [NSEL-1:0] select_strobes_oe,
	// other bus signals enable
	output logic                 bus_signals_oe,
	// sharing mode and external master memory access
	input  wire logic            peripheral_sharing_mode,
	input  wire logic            ext_rd_n,
	input  wire logic            ext_wr_n,
	input  wire logic [AW-1:0]   ext_addr,
	input  wire logic [DW-1:0]   ext_wdata,
	output logic      [DW-1:0]   ext_rdata,
	output logic                 ext_data_oe
);
	arb_state_e        state_r, state_nxt;
	logic [CNT_W-1:0]  cnt_r, cnt_nxt;
	logic              yield_acknowledge_r, bus_reclaim_request_r;
	logic [NSEL-1:0]   sel_o_r, sel_oe_r;
	logic              bus_oe_r;

	wire hold_asked   = !hold_req_n;
	wire mem_access   = (state_r == ST_HELD) && peripheral_sharing_mode;
	wire drive_done   = (cnt_r == CNT_ONE) || (cnt_r == CNT_ZERO);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			ST_OWN: begin
				if (hold_asked) begin
					state_nxt = ST_FINISH;
				end
			end
			ST_FINISH: begin
				// cycle must end before acknowledge
				if (!cycle_busy) begin
					state_nxt = ST_DRIVE_HIGH;
					cnt_nxt   = CNT_W'(HALF_PERIOD_CYC);
				end
			end
			ST_DRIVE_HIGH: begin
				cnt_nxt = cnt_r - CNT_ONE;
				if (drive_done) begin
					state_nxt = ST_HELD;
				end
			end
			ST_HELD: begin
				// level, not edge: a release during finish would else hang here
				if (hold_req_n) begin
					state_nxt = ST_REGAIN;
				end
			end
			ST_REGAIN: begin
				state_nxt = ST_OWN;
			end
			default: begin
				state_nxt = ST_OWN;
			end
		endcase
	end

	wire held_or_drv = (state_nxt == ST_DRIVE_HIGH) || (state_nxt == ST_HELD);
	wire own_nxt     = (state_nxt == ST_OWN) || (state_nxt == ST_FINISH);
	wire drv_high    = state_nxt == ST_DRIVE_HIGH;

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_r     <= ST_OWN;
			cnt_r       <= '0;
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			yield_acknowledge_r   <= 1'b1;
			bus_reclaim_request_r   <= 1'b1;
			sel_o_r  <= '1;
			sel_oe_r <= '1;
			bus_oe_r <= 1'b1;
		end else begin
			yield_acknowledge_r   <= !(held_or_drv || state_nxt == ST_REGAIN && 1'b0);
			bus_reclaim_request_r   <= !((state_nxt == ST_HELD) && access_pending);
			bus_oe_r <= own_nxt;
			for (int i = 0; i < NSEL; i++) begin
				if (own_nxt) begin
					sel_o_r[i]  <= sel_value_n[i];
					sel_oe_r[i] <= 1'b1;
				end else if (drv_high && sel_latched[i]) begin
					sel_o_r[i]  <= 1'b1;
					sel_oe_r[i] <= 1'b1;
				end else begin
					sel_o_r[i]  <= 1'b1;
					sel_oe_r[i] <= 1'b0;
				end
			end
		end
	end

	assign yield_acknowledge_n   = yield_acknowledge_r;
	assign bus_reclaim_request_n = bus_reclaim_request_r;
	assign bus_owned             = state_r == ST_OWN;
	assign select_strobes_o      = sel_o_r;
	assign select_strobes_oe     = sel_oe_r;
	assign bus_signals_oe        = bus_oe_r;

	ext_memory_port #(
		.AW (AW),
		.DW (DW)
	) u_mem (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.access_en   (mem_access),
		.ext_rd_n    (ext_rd_n),
		.ext_wr_n    (ext_wr_n),
		.ext_addr    (ext_addr),
		.ext_wdata   (ext_wdata),
		.ext_rdata   (ext_rdata),
		.ext_data_oe (ext_data_oe)
	);
endmodule

// File: verilog/bus_hold_pkg.sv
// shared constants for the external bus hold arbiter
package bus_hold_pkg;
	localparam int          SYS_CLK_PERIOD_PS = 5000;
	// half period unit of the reference clock output, in ps
	localparam int          HALF_PERIOD_PS    = 5000;
	localparam int          HALF_PERIOD_CYC   = (HALF_PERIOD_PS + SYS_CLK_PERIOD_PS - 1)
		/ SYS_CLK_PERIOD_PS;
	localparam int          CNT_W             = 4;
	localparam int          MEM_ADDR_W        = 10;
	localparam int          MEM_DATA_W        = 16;
	localparam int          NUM_SEL           = 5;
	localparam logic [3:0]  CNT_ZERO          = 4'h0;
	localparam logic [3:0]  CNT_ONE           = 4'h1;
	typedef enum logic [2:0] {
		ST_OWN,
		ST_FINISH,
		ST_DRIVE_HIGH,
		ST_HELD,
		ST_REGAIN
	} arb_state_e;
endpackage

// File: verilog/ext_memory_port.sv
// on-chip extension memory reached by the external master as async sram
module ext_memory_port
	import bus_hold_pkg::*;
#(
	parameter int AW = MEM_ADDR_W,
	parameter int DW = MEM_DATA_W
) (
	// clock and reset
	input  wire logic          sys_clk,
	input  wire logic          reset_n,
	// gate from the arbiter
	input  wire logic          access_en,
	// external master strobes, active low
	input  wire logic          ext_rd_n,
	input  wire logic          ext_wr_n,
	input  wire logic [AW-1:0] ext_addr,
	input  wire logic [DW-1:0] ext_wdata,
	// data pins
	output logic      [DW-1:0] ext_rdata,
	output logic               ext_data_oe
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic          wr_prev_r;
	logic [DW-1:0] rdata_r;
	logic          oe_r;
	wire           wr_rise = access_en && ext_wr_n && !wr_prev_r;
	wire           rd_act  = access_en && !ext_rd_n;

	// write lands on the trailing edge of the strobe, like an sram
	always_ff @(posedge sys_clk) begin
		if (wr_rise) begin
			mem[ext_addr] <= ext_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wr_prev_r <= 1'b1;
			rdata_r   <= '0;
			oe_r      <= 1'b0;
		end else begin
			wr_prev_r <= ext_wr_n | ~access_en;
			oe_r      <= rd_act;
			if (rd_act) begin
				rdata_r <= mem[ext_addr];
			end
		end
	end

	assign ext_rdata   = rdata_r;
	assign ext_data_oe = oe_r;
endmodule

// File: sim/bus_hold_assertions.sv
// port checks on the bus hold arbiter
module bus_hold_checker #(parameter int NSEL = 5) (
	input wire logic		sys_clk,
	input wire logic		reset_n,
	input wire logic		hold_req_n,
	input wire logic		yield_acknowledge_n,
	input wire logic		bus_reclaim_request_n,
	input wire logic		bus_owned,
	input wire logic		cycle_busy,
	input wire logic		access_pending,
	input wire logic		peripheral_sharing_mode,
	input wire logic		ext_rd_n,
	input wire logic		ext_data_oe,
	input wire logic [NSEL-1:0]	sel_latched,
	input wire logic [NSEL-1:0]	select_strobes_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire ack = !yield_acknowledge_n;
	sequence yield_s; $fell(yield_acknowledge_n); endsequence
	sequence held_s; ack && $past(ack); endsequence
	finish_first_a: assert property (yield_s |-> !$past(cycle_busy))
		else $error("ack inside cycle");
	release_oe_a: assert property (yield_s |=> select_strobes_oe == '0)
		else $error("strobes driven");
	latched_high_a: assert property (yield_s |-> select_strobes_oe == sel_latched)
		else $error("latched strobes");
	hold_stays_a: assert property (held_s and !hold_req_n |=> ack)
		else $error("early regain");
	regain_a: assert property (ack && $rose(hold_req_n) |-> ##[1:4] bus_owned)
		else $error("no regain");
	mem_read_a: assert property (held_s and peripheral_sharing_mode && !ext_rd_n |=> ext_data_oe)
		else $error("no read data");
	reclaim_a: assert property (held_s and access_pending |=> !bus_reclaim_request_n || !ack)
		else $error("no reclaim");
	reclaim_off_a: assert property (bus_owned [*2] |-> bus_reclaim_request_n)
		else $error("reclaim kept");
endmodule
bind bus_hold_arbiter bus_hold_checker #(.NSEL(NSEL)) i_chk (.*);

// File: sim/hold_master_model.sv
// external master asking for the bus
module hold_master_model (
	input wire logic	sys_clk,
	input wire logic	go,
	input wire logic [4:0]	hold_cyc,
	output logic		hold_req_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt_r = 5'h00;
	initial hold_req_n = 1'b1;
	// lets go after hold_cyc + 1 cycles, granted or not
	always @(posedge sys_clk)
		if (hold_req_n) begin
			hold_req_n <= !go;
			cnt_r <= 5'h00;
		end else begin
			cnt_r <= cnt_r + 5'h01;
			hold_req_n <= (cnt_r == hold_cyc);
		end
endmodule

// File: sim/external_bus_hold_arbitration_tb_top.sv
// bench for the bus hold arbiter
module external_bus_hold_arbitration_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic		sys_clk = 0, reset_n = 0, go = 0, cycle_busy = 0, access_pending = 0;
	logic		psm = 0, ext_rd_n = 1, ext_wr_n = 1, hold_req_n, ack_n, recl_n, owned, oe;
	logic		bus_oe;
	logic [4:0]	hold_cyc = 5'h1f, sel_oe;
	logic [9:0]	addr = 10'h000;
	logic [15:0]	wdata = 16'h0000, rdata, exp_q[$];
	int		error_cnt = 0, n_checks = 0;
	bus_hold_arbiter i_dut (.sys_clk, .reset_n, .hold_req_n, .yield_acknowledge_n(ack_n),
		.bus_reclaim_request_n(recl_n), .cycle_busy, .access_pending, .sel_latched(5'h15),
		.sel_value_n(5'h0a), .bus_owned(owned), .select_strobes_o(),
		.select_strobes_oe(sel_oe), .bus_signals_oe(bus_oe), .peripheral_sharing_mode(psm),
		.ext_rd_n, .ext_wr_n, .ext_addr(addr), .ext_wdata(wdata), .ext_rdata(rdata),
		.ext_data_oe(oe));
	hold_master_model i_master (.sys_clk, .go, .hold_cyc, .hold_req_n);
	initial forever #2.5 sys_clk = ~sys_clk;
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(negedge sys_clk)
		if (oe === 1'b1)
			chk("read", rdata, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
	initial begin
		#100us;
		error_cnt++;
		summarize();
	end
	initial begin
		int k;
		void'($urandom(32'h0bd4));
		repeat (10) @(negedge sys_clk);
		reset_n = 1;
		for (int i = 0; i < 30; i++) begin
			access_pending = 1'($urandom);
			hold_cyc = (i % 3) ? 5'h1f : 5'h02;
			go = 1;
			cycle_busy = 1;
			@(negedge sys_clk);
			go = 0;
			repeat ($urandom % 4) begin
				chk("ack", ack_n, 1);
				@(negedge sys_clk);
			end
			cycle_busy = 0;
			for (k = 0; k < 9 && !(ack_n === 0 && sel_oe === 0); k++)
				@(negedge sys_clk);
			chk("strobes off", sel_oe, 5'h00);
			chk("bus oe", bus_oe, 0);
			if (hold_cyc[4]) begin
				psm = 1'($urandom);
				addr = 10'($urandom);
				wdata = 16'($urandom);
				ext_wr_n = 0;
				repeat (2) @(negedge sys_clk);
				ext_wr_n = 1;
				chk("reclaim", recl_n, !access_pending);
				@(negedge sys_clk);
				ext_rd_n = 0;
				if (psm)
					exp_q.push_back(wdata);
				@(negedge sys_clk);
				ext_rd_n = 1;
				psm = 0;
			end
			for (k = 0; k < 40 && owned !== 1; k++)
				@(negedge sys_clk);
			@(negedge sys_clk);
			chk("owned", owned, 1);
		end
		summarize();
	end
endmodule
